// *** rxagc_pkg.sv ***
// constants shared by the receiver gain control block
package rxagc_pkg;

	// ==========================================
	// register bus
	localparam int REG_W = 8;
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] ADDR_SENSE_CFG = 8'h11;
	localparam logic [ADDR_W-1:0] ADDR_GAIN_CFG = 8'h12;
	localparam logic [ADDR_W-1:0] ADDR_DOWN_START = 8'h13;
	localparam logic [ADDR_W-1:0] ADDR_UP_REF = 8'h14;
	localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h18;
	localparam logic [ADDR_W-1:0] ADDR_AVG_MAG = 8'h19;

	// ==========================================
	// reset values
	localparam logic [REG_W-1:0] RST_SENSE_CFG = 8'h44;
	localparam logic [REG_W-1:0] RST_GAIN_CFG = 8'h75;
	localparam logic [REG_W-1:0] RST_DOWN_START = 8'h38;
	localparam logic [REG_W-1:0] RST_UP_REF = 8'h38;
	localparam logic [REG_W-1:0] SENSE_CFG_MASK = 8'hdc;

	// ==========================================
	// field positions
	localparam int F_LOW_LIMIT = 7;
	localparam int F_HIGH_LIMIT = 6;
	localparam int F_SWITCH_LSB = 4;
	localparam int F_GAIN_OFF = 3;
	localparam int F_HYST = 2;
	localparam int F_AVG_LSB = 0;
	localparam int F_MARGIN_LSB = 5;
	localparam int F_SETTING_LSB = 0;
	localparam int F_CS_COUNT_LSB = 6;
	localparam int F_WAIT_LSB = 2;
	localparam int F_STAT_SENSE = 7;
	localparam int F_STAT_STEP_LSB = 5;

	// ==========================================
	// gain steps and switch points
	localparam int GAIN_W = 5;
	localparam logic [1:0] AMP_MIN = 2'h0;
	localparam logic [1:0] AMP_MED = 2'h1;
	localparam logic [1:0] AMP_MAX = 2'h2;
	localparam logic [1:0] AMP_MED_MAX = 2'h3;
	localparam logic [5:0] SWITCH_NEAR_THIRD = 6'h0a;
	localparam logic [5:0] SWITCH_NEAR_TWO_THIRDS = 6'h13;
	localparam logic [5:0] SWITCH_ABOVE_MAX = 6'h20;
	// 4.5 dB base margin in 1.5 dB level steps
	localparam int DOWN_BASE_STEPS = 3;

	// ==========================================
	// freeze periods in filter clocks
	localparam int FRZ_W = 6;
	localparam logic [2:0] FRZ_HOLD_CODE = 3'h7;
	localparam logic [FRZ_W-1:0] FRZ_CLKS [0:6] = '{6'h10, 6'h14, 6'h18, 6'h1c, 6'h20,
		6'h28, 6'h30};

endpackage : rxagc_pkg

// *** rxagc_run_count.sv ***
// counter of consecutive samples meeting a condition
`timescale 1ns/1ns
module rxagc_run_count #(
	parameter int CNT_W = 3
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic sampleEn,
	input wire logic clear,
	input wire logic cond,
	input wire logic [CNT_W-1:0] need,
	output logic reached
);
	import rxagc_pkg::*;

	typedef struct packed {
		logic [CNT_W-1:0] cnt;
	} rxagc_run_state_t;

	rxagc_run_state_t s_reg;
	rxagc_run_state_t s_next;

	always_comb begin
		s_next = s_reg;
		if (clear) begin
			s_next.cnt = '0;
		end else if (sampleEn) begin
			if (!cond) begin
				s_next.cnt = '0;
			end else if (s_reg.cnt != '1) begin
				s_next.cnt = s_reg.cnt + 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign reached = (s_reg.cnt >= need) && (need != '0);

endmodule : rxagc_run_count

// *** rxagc_avg.sv ***
// block averager of filter output magnitude over 2 to 16 samples
`timescale 1ns/1ns
module rxagc_avg #(
	parameter int MAG_W = 8,
	parameter int LOG_MAX = 4
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic sampleEn,
	input wire logic clear,
	input wire logic [1:0] lengthCode,
	input wire logic [MAG_W-1:0] sample,
	output logic avgValid,
	output logic [MAG_W-1:0] avgOut
);
	import rxagc_pkg::*;

	localparam int ACC_W = MAG_W + LOG_MAX;

	typedef struct packed {
		logic [ACC_W-1:0] acc;
		logic [LOG_MAX-1:0] cnt;
		logic [MAG_W-1:0] avg;
		logic valid;
	} rxagc_avg_state_t;

	rxagc_avg_state_t s_reg;
	rxagc_avg_state_t s_next;
	logic [ACC_W-1:0] sum;
	logic [ACC_W-1:0] scaled;
	logic [LOG_MAX-1:0] lastIdx;

	always_comb begin
		s_next = s_reg;
		s_next.valid = 1'b0;
		sum = s_reg.acc + ACC_W'(sample);
		scaled = sum >> (32'(lengthCode) + 1);
		lastIdx = LOG_MAX'((2 << lengthCode) - 1);
		if (clear) begin
			s_next.acc = '0;
			s_next.cnt = '0;
		end else if (sampleEn) begin
			if (s_reg.cnt >= lastIdx) begin
				s_next.avg = scaled[MAG_W-1:0];
				s_next.valid = 1'b1;
				s_next.acc = '0;
				s_next.cnt = '0;
			end else begin
				s_next.acc = sum;
				s_next.cnt = s_reg.cnt + 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign avgValid = s_reg.valid;
	assign avgOut = s_reg.avg;

endmodule : rxagc_avg

// *** rxagc_top.sv ***
// receiver gain control: averaging, gain stepping, second amp step, carrier sense
`timescale 1ns/1ns
module rxagc_top #(
	parameter int MAG_W = 8
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic [rxagc_pkg::ADDR_W-1:0] regAddr,
	input wire logic [rxagc_pkg::REG_W-1:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	output logic [rxagc_pkg::REG_W-1:0] regRdData,
	input wire logic filterClkEn,
	input wire logic magValid,
	input wire logic [MAG_W-1:0] magSample,
	input wire logic rxOn,
	input wire logic freezeTrigger,
	output logic [rxagc_pkg::GAIN_W-1:0] ampGain,
	output logic [1:0] secondAmpGain,
	output logic carrierSense,
	output logic freezeActive
);
	import rxagc_pkg::*;

	typedef struct packed {
		logic [REG_W-1:0] senseReg;
		logic [REG_W-1:0] cfgReg;
		logic [REG_W-1:0] downReg;
		logic [REG_W-1:0] upReg;
		logic [GAIN_W-1:0] gain;
		logic [1:0] step;
		logic sense;
		logic freezing;
		logic [FRZ_W-1:0] frzCnt;
		logic decide;
		logic [REG_W-1:0] rdData;
	} rxagc_top_state_t;

	rxagc_top_state_t s_reg;
	rxagc_top_state_t s_next;

	// ==========================================
	// configuration fields
	logic second_amp_low_limit;
	logic second_amp_high_limit;
	logic [1:0] second_amp_switch_point;
	logic gain_control_off;
	logic gain_step_hysteresis;
	logic [1:0] magnitude_average_length;
	logic [2:0] downMargin;
	logic [GAIN_W-1:0] startSetting;
	logic [2:0] upOffset;
	logic [4:0] refLevel;
	logic [1:0] senseCount;
	logic [2:0] waitCode;

	assign second_amp_low_limit = s_reg.cfgReg[F_LOW_LIMIT];
	assign second_amp_high_limit = s_reg.cfgReg[F_HIGH_LIMIT];
	assign second_amp_switch_point = s_reg.cfgReg[F_SWITCH_LSB +: 2];
	assign gain_control_off = s_reg.cfgReg[F_GAIN_OFF];
	assign gain_step_hysteresis = s_reg.cfgReg[F_HYST];
	assign magnitude_average_length = s_reg.cfgReg[F_AVG_LSB +: 2];
	assign downMargin = s_reg.downReg[F_MARGIN_LSB +: 3];
	assign startSetting = s_reg.downReg[F_SETTING_LSB +: GAIN_W];
	assign upOffset = s_reg.upReg[F_MARGIN_LSB +: 3];
	assign refLevel = s_reg.upReg[F_SETTING_LSB +: 5];
	assign senseCount = s_reg.senseReg[F_CS_COUNT_LSB +: 2];
	assign waitCode = s_reg.senseReg[F_WAIT_LSB +: 3];

	// ==========================================
	// averaging and thresholds
	logic avgValid;
	logic [MAG_W-1:0] avgMag;
	logic [MAG_W-1:0] upLevel;
	logic [MAG_W-1:0] downLevel;
	logic upCond;
	logic downCond;
	logic senseCond;
	logic upHit;
	logic downHit;
	logic senseHit;
	logic [2:0] stepNeed;
	logic [2:0] senseNeed;
	logic restart;
	logic gainMoved;

	assign restart = rxOn || freezeTrigger;

	rxagc_avg #(
		.MAG_W(MAG_W),
		.LOG_MAX(4)
	) u_avg (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.sampleEn(magValid && !s_reg.freezing),
		.clear(restart),
		.lengthCode(magnitude_average_length),
		.sample(magSample),
		.avgValid(avgValid),
		.avgOut(avgMag)
	);

	assign upLevel = MAG_W'(refLevel) + MAG_W'(upOffset);
	assign downLevel = upLevel + MAG_W'(DOWN_BASE_STEPS) + MAG_W'(downMargin);
	assign upCond = avgMag < upLevel;
	assign downCond = avgMag > downLevel;
	assign senseCond = avgMag >= MAG_W'(refLevel);
	assign stepNeed = gain_step_hysteresis ? 3'h2 : 3'h1;
	assign senseNeed = 3'(senseCount) + 3'h1;

	rxagc_run_count #(
		.CNT_W(3)
	) u_up_run (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.sampleEn(avgValid),
		.clear(gainMoved || restart),
		.cond(upCond),
		.need(stepNeed),
		.reached(upHit)
	);

	rxagc_run_count #(
		.CNT_W(3)
	) u_down_run (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.sampleEn(avgValid),
		.clear(gainMoved || restart),
		.cond(downCond),
		.need(stepNeed),
		.reached(downHit)
	);

	rxagc_run_count #(
		.CNT_W(3)
	) u_sense_run (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.sampleEn(avgValid),
		.clear(restart),
		.cond(senseCond),
		.need(senseNeed),
		.reached(senseHit)
	);

	// ==========================================
	// second amplifier step for a given gain
	function automatic logic [1:0] second_amp_step(input logic [GAIN_W-1:0] g,
		input logic lowLim, input logic highLim, input logic [1:0] sw);
		logic [5:0] point;
		logic [1:0] lowStep;
		logic [1:0] highStep;
		point = 6'h00;
		lowStep = lowLim ? AMP_MED : AMP_MIN;
		highStep = highLim ? AMP_MAX : AMP_MED;
		case (sw)
			2'h1: point = SWITCH_NEAR_THIRD;
			2'h2: point = SWITCH_NEAR_TWO_THIRDS;
			2'h3: point = SWITCH_ABOVE_MAX;
			default: point = 6'h00;
		endcase
		if (lowLim && !highLim) begin
			case (sw)
				2'h0: second_amp_step = AMP_MED_MAX;
				2'h1: second_amp_step = AMP_MIN;
				2'h2: second_amp_step = AMP_MED;
				default: second_amp_step = AMP_MAX;
			endcase
		end else if (6'(g) >= point) begin
			second_amp_step = highStep;
		end else begin
			second_amp_step = lowStep;
		end
	endfunction : second_amp_step

	// ==========================================
	// gain decisions and freeze window helpers
	logic decideNow;
	logic stepDown;
	logic stepUp;
	logic overCeiling;
	logic frzHold;
	logic frzTick;
	logic [FRZ_W-1:0] frzLoad;
	logic [REG_W-1:0] statusWord;

	// decisions only on a fresh average outside the freeze window
	assign decideNow = s_reg.decide && !s_reg.freezing;
	assign stepDown = downHit && (s_reg.gain != '0);
	assign stepUp = upHit && (s_reg.gain < startSetting);
	// ceiling lowered by software below the present gain
	assign overCeiling = s_reg.gain > startSetting;
	// hold code keeps the window open until the code is rewritten
	assign frzHold = (waitCode == FRZ_HOLD_CODE);
	assign frzTick = s_reg.freezing && filterClkEn && !frzHold;
	assign frzLoad = frzHold ? '0 : FRZ_CLKS[waitCode];
	assign statusWord = {s_reg.sense, s_reg.step, s_reg.gain};

	// ==========================================
	// next state
	always_comb begin
		s_next = s_reg;
		s_next.decide = avgValid;
		s_next.rdData = '0;

		if (regWr) begin
			if (regAddr == ADDR_SENSE_CFG) begin
				s_next.senseReg = regWrData & SENSE_CFG_MASK;
			end else if (regAddr == ADDR_GAIN_CFG) begin
				s_next.cfgReg = regWrData;
			end else if (regAddr == ADDR_DOWN_START) begin
				s_next.downReg = regWrData;
			end else if (regAddr == ADDR_UP_REF) begin
				s_next.upReg = regWrData;
			end
		end

		if (regRd) begin
			if (regAddr == ADDR_SENSE_CFG) begin
				s_next.rdData = s_reg.senseReg;
			end else if (regAddr == ADDR_GAIN_CFG) begin
				s_next.rdData = s_reg.cfgReg;
			end else if (regAddr == ADDR_DOWN_START) begin
				s_next.rdData = s_reg.downReg;
			end else if (regAddr == ADDR_UP_REF) begin
				s_next.rdData = s_reg.upReg;
			end else if (regAddr == ADDR_STATUS) begin
				s_next.rdData = statusWord;
			end else if (regAddr == ADDR_AVG_MAG) begin
				s_next.rdData = REG_W'(avgMag);
			end
		end

		// freeze window counted in filter clocks
		if (restart) begin
			s_next.freezing = 1'b1;
			s_next.frzCnt = frzLoad;
		end else if (frzTick) begin
			if (s_reg.frzCnt <= FRZ_W'(1)) begin
				s_next.freezing = 1'b0;
				s_next.frzCnt = '0;
			end else begin
				s_next.frzCnt = s_reg.frzCnt - 1'b1;
			end
		end

		// gain stepping
		if (rxOn || gain_control_off) begin
			s_next.gain = startSetting;
		end else if (decideNow) begin
			if (stepDown) begin
				s_next.gain = s_reg.gain - 1'b1;
			end else if (stepUp) begin
				s_next.gain = s_reg.gain + 1'b1;
			end else if (overCeiling) begin
				s_next.gain = startSetting;
			end
		end

		s_next.step = second_amp_step(s_next.gain, second_amp_low_limit,
			second_amp_high_limit, second_amp_switch_point);
		s_next.sense = senseHit && !restart;
	end

	assign gainMoved = s_reg.decide && (s_next.gain != s_reg.gain);

	// ==========================================
	// state register
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			s_reg <= '0;
			s_reg.senseReg <= RST_SENSE_CFG;
			s_reg.cfgReg <= RST_GAIN_CFG;
			s_reg.downReg <= RST_DOWN_START;
			s_reg.upReg <= RST_UP_REF;
			s_reg.gain <= RST_DOWN_START[F_SETTING_LSB +: GAIN_W];
			// step matching the reset gain, so no jump on the first edge
			s_reg.step <= second_amp_step(RST_DOWN_START[F_SETTING_LSB +: GAIN_W],
				RST_GAIN_CFG[F_LOW_LIMIT], RST_GAIN_CFG[F_HIGH_LIMIT],
				RST_GAIN_CFG[F_SWITCH_LSB +: 2]);
		end else begin
			s_reg <= s_next;
		end
	end

	assign regRdData = s_reg.rdData;
	assign ampGain = s_reg.gain;
	assign secondAmpGain = s_reg.step;
	assign carrierSense = s_reg.sense;
	assign freezeActive = s_reg.freezing;

endmodule : rxagc_top

// *** rxagc_checker.sv ***
// assertion checker for the receiver gain control top
`timescale 1ns/1ns
module rxagc_checker #(
	parameter int MAG_W = 8
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic [rxagc_pkg::ADDR_W-1:0] regAddr,
	input wire logic [rxagc_pkg::REG_W-1:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	input wire logic [rxagc_pkg::REG_W-1:0] regRdData,
	input wire logic filterClkEn,
	input wire logic magValid,
	input wire logic [MAG_W-1:0] magSample,
	input wire logic rxOn,
	input wire logic freezeTrigger,
	input wire logic [rxagc_pkg::GAIN_W-1:0] ampGain,
	input wire logic [1:0] secondAmpGain,
	input wire logic carrierSense,
	input wire logic freezeActive
);
	import rxagc_pkg::*;
	// ==========================================
	// shadow registers and freeze pulse count
	logic [REG_W-1:0] senseReg, cfgReg, cfgPrev, dnReg, upReg, expRd;
	logic [FRZ_W-1:0] frzCnt;
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			senseReg <= RST_SENSE_CFG;
			cfgReg <= RST_GAIN_CFG;
			cfgPrev <= RST_GAIN_CFG;
			dnReg <= RST_DOWN_START;
			upReg <= RST_UP_REF;
			frzCnt <= '0;
		end else begin
			cfgPrev <= cfgReg;
			if (regWr && regAddr == ADDR_SENSE_CFG) senseReg <= regWrData & SENSE_CFG_MASK;
			if (regWr && regAddr == ADDR_GAIN_CFG) cfgReg <= regWrData;
			if (regWr && regAddr == ADDR_DOWN_START) dnReg <= regWrData;
			if (regWr && regAddr == ADDR_UP_REF) upReg <= regWrData;
			if (rxOn || freezeTrigger) frzCnt <= '0;
			else if (freezeActive && filterClkEn) frzCnt <= frzCnt + FRZ_W'(1);
		end
	end
	always_comb begin
		case (regAddr)
			ADDR_SENSE_CFG: expRd = senseReg;
			ADDR_GAIN_CFG: expRd = cfgReg;
			ADDR_DOWN_START: expRd = dnReg;
			ADDR_UP_REF: expRd = upReg;
			default: expRd = '0;
		endcase
	end
	// expected second amp step for a gain and a config byte
	function automatic logic [1:0] expStep(input logic [GAIN_W-1:0] g,
		input logic [REG_W-1:0] c);
		logic [5:0] pt;
		case (c[F_SWITCH_LSB +: 2])
			2'h1: pt = SWITCH_NEAR_THIRD;
			2'h2: pt = SWITCH_NEAR_TWO_THIRDS;
			2'h3: pt = SWITCH_ABOVE_MAX;
			default: pt = 6'h00;
		endcase
		if (c[F_LOW_LIMIT] && !c[F_HIGH_LIMIT]) begin
			case (c[F_SWITCH_LSB +: 2])
				2'h0: return AMP_MED_MAX;
				2'h1: return AMP_MIN;
				2'h2: return AMP_MED;
				default: return AMP_MAX;
			endcase
		end
		if ({1'b0, g} < pt) begin
			return c[F_LOW_LIMIT] ? AMP_MED : AMP_MIN;
		end
		return c[F_HIGH_LIMIT] ? AMP_MAX : AMP_MED;
	endfunction : expStep
	// ==========================================
	// properties
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	sequence frozenRun;
		freezeActive [*4];
	endsequence
	sequence offSteady;
		cfgReg[F_GAIN_OFF] && $past(cfgReg[F_GAIN_OFF]) && $stable(dnReg);
	endsequence
	a_read_idle: assert property (!$past(regRd) |-> regRdData == '0)
		else $error("read data not zero outside read answer");
	a_read_data: assert property (regRd && regAddr != ADDR_STATUS
		&& regAddr != ADDR_AVG_MAG |=> regRdData == $past(expRd))
		else $error("read data differs from written value");
	a_start_load: assert property (rxOn |=> ampGain == $past(dnReg[4:0]))
		else $error("start gain not loaded at receive on");
	a_gain_off_hold: assert property (offSteady |=> ampGain == $past(dnReg[4:0]))
		else $error("gain not held at setting while control off");
	a_step_one: assert property (ampGain != $past(ampGain)
		&& !$past(cfgReg[F_GAIN_OFF]) && !$past(rxOn) && ampGain != dnReg[4:0]
		|-> GAIN_W'(ampGain - $past(ampGain)) inside {5'h01, 5'h1f})
		else $error("gain moved by more than one step");
	a_freeze_start: assert property (rxOn || freezeTrigger |=> freezeActive)
		else $error("freeze did not start");
	a_freeze_length: assert property ($fell(freezeActive)
		|-> senseReg[4:2] == FRZ_HOLD_CODE || frzCnt == FRZ_CLKS[senseReg[4:2]])
		else $error("freeze length wrong");
	a_frozen_hold: assert property (frozenRun ##0 (!cfgReg[F_GAIN_OFF]
		&& !$past(cfgReg[F_GAIN_OFF]) && !$past(rxOn) && $stable(dnReg))
		|-> $stable(ampGain))
		else $error("gain changed while frozen");
	a_amp_step_map: assert property (secondAmpGain == expStep(ampGain, cfgPrev))
		else $error("second amp step does not match gain and limits");
endmodule : rxagc_checker

bind rxagc_top rxagc_checker #(.MAG_W(MAG_W)) i_rxagc_checker (.clk_sys(clk_sys),
	.sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
	.regRdData(regRdData), .filterClkEn(filterClkEn), .magValid(magValid),
	.magSample(magSample), .rxOn(rxOn), .freezeTrigger(freezeTrigger), .ampGain(ampGain),
	.secondAmpGain(secondAmpGain), .carrierSense(carrierSense), .freezeActive(freezeActive));

// *** rxagc_partner.sv ***
// model of the amplifier chain and channel filter feeding the gain control
`timescale 1ns/1ns
module rxagc_partner (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic slow,
	input wire logic [rxagc_pkg::GAIN_W-1:0] ampGain,
	input wire logic [7:0] sigLevel,
	output logic filterClkEn,
	output logic magValid,
	output logic [7:0] magSample
);
	import rxagc_pkg::*;
	logic [1:0] cnt;
	logic nextValid;
	logic [7:0] level;
	assign nextValid = cnt[0] & (~slow | cnt[1]);
	// gain adds to the antenna level; line toggles between samples
	assign level = sigLevel + {3'h0, ampGain};
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			cnt <= '0;
			filterClkEn <= 1'b0;
			magValid <= 1'b0;
			magSample <= '0;
		end else begin
			cnt <= cnt + 2'h1;
			filterClkEn <= cnt[0];
			magValid <= nextValid;
			magSample <= nextValid ? level : ~level;
		end
	end
endmodule : rxagc_partner

// *** rxagc_top_tb.sv ***
// self-checking bench for the receiver gain control block
`timescale 1ns/1ns
module rxagc_top_tb;
	import rxagc_pkg::*;
	logic clk_sys, sys_rst, regWr, regRd, rxOn, freezeTrigger, filterClkEn, magValid, slow;
	logic carrierSense, freezeActive;
	logic [7:0] regAddr, regWrData, regRdData, v, cfg, up, magSample, sigLevel;
	logic [GAIN_W-1:0] ampGain, s;
	logic [1:0] secondAmpGain;
	int miscompares, samples_checked;

	rxagc_top #(.MAG_W(8)) i_rxagc_top (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
		.regRdData(regRdData), .filterClkEn(filterClkEn), .magValid(magValid),
		.magSample(magSample), .rxOn(rxOn), .freezeTrigger(freezeTrigger), .ampGain(ampGain),
		.secondAmpGain(secondAmpGain), .carrierSense(carrierSense), .freezeActive(freezeActive));
	rxagc_partner i_rxagc_partner (.clk_sys(clk_sys), .sys_rst(sys_rst), .slow(slow),
		.ampGain(ampGain), .sigLevel(sigLevel), .filterClkEn(filterClkEn),
		.magValid(magValid), .magSample(magSample));

	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end

	task automatic complete_run;
		$display("compared %0d, mismatched %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : complete_run

	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		regAddr <= a;
		regWrData <= d;
		regWr <= 1'b1;
		@(posedge clk_sys);
		regWr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk_sys);
		regRd <= 1'b0;
		#1 d = regRdData;
	endtask : rd

	// poll a register until it settles, at most lim extra reads
	task automatic rdWait(input logic [7:0] a, input logic [7:0] e, input int lim);
		int n;
		logic [7:0] d;
		n = 0;
		rd(a, d);
		while (d !== e && n < lim) begin
			rd(a, d);
			n++;
		end
		cmp(d, e);
		if (d !== e && n >= lim) complete_run();
	endtask : rdWait

	task automatic pulse(input logic isRxOn);
		@(posedge clk_sys);
		if (isRxOn) rxOn <= 1'b1;
		else freezeTrigger <= 1'b1;
		@(posedge clk_sys);
		rxOn <= 1'b0;
		freezeTrigger <= 1'b0;
	endtask : pulse

	function automatic logic [1:0] expSec(input logic [7:0] c, input logic [4:0] g);
		logic [7:0] direct;
		logic [23:0] pts;
		direct = {AMP_MAX, AMP_MED, AMP_MIN, AMP_MED_MAX};
		pts = {SWITCH_ABOVE_MAX, SWITCH_NEAR_TWO_THIRDS, SWITCH_NEAR_THIRD, 6'h00};
		if (c[F_LOW_LIMIT] && !c[F_HIGH_LIMIT]) return direct[2*c[5:4] +: 2];
		if ({1'b0, g} >= pts[6*c[5:4] +: 6]) return c[F_HIGH_LIMIT] ? AMP_MAX : AMP_MED;
		return c[F_LOW_LIMIT] ? AMP_MED : AMP_MIN;
	endfunction : expSec

	initial begin
		sys_rst = 1'b1;
		regAddr = '0;
		regWrData = '0;
		regWr = 1'b0;
		regRd = 1'b0;
		rxOn = 1'b0;
		freezeTrigger = 1'b0;
		sigLevel = '0;
		slow = 1'b0;
		miscompares = 0;
		samples_checked = 0;
		void'($urandom(54));
		repeat (2) @(posedge clk_sys);
		sys_rst <= 1'b0;
		rdWait(ADDR_SENSE_CFG, RST_SENSE_CFG, 0);
		rdWait(ADDR_GAIN_CFG, RST_GAIN_CFG, 0);
		rdWait(ADDR_DOWN_START, RST_DOWN_START, 0);
		rdWait(ADDR_UP_REF, RST_UP_REF, 0);
		wr(8'h20, 8'hff);
		rdWait(8'h20, 8'h00, 0);
		cmp({3'h0, ampGain}, 8'h18);
		cmp({6'h0, secondAmpGain}, {6'h0, expSec(RST_GAIN_CFG, RST_DOWN_START[4:0])});
		cmp({7'h0, freezeActive}, 8'h00);
		$display("test reset values done");
		for (int i = 0; i < 8; i++) begin
			v = 8'h11 + 8'(i % 4);
			cfg = 8'($urandom);
			wr(v, cfg);
			rdWait(v, (v == ADDR_SENSE_CFG) ? (cfg & SENSE_CFG_MASK) : cfg, 0);
		end
		wr(ADDR_SENSE_CFG, RST_SENSE_CFG);
		$display("test register access done");
		// every limit and switch code with gain held, all averaging lengths
		for (int i = 0; i < 16; i++) begin
			s = 5'($urandom);
			up = 8'($urandom);
			cfg = {4'(i), 1'b1, 1'($urandom), 2'(i)};
			sigLevel <= 8'($urandom_range(40));
			slow <= i[0];
			wr(ADDR_GAIN_CFG, cfg);
			wr(ADDR_DOWN_START, {3'($urandom), s});
			wr(ADDR_UP_REF, up);
			rdWait(ADDR_AVG_MAG, sigLevel + 8'(s), 100);
			v = {(sigLevel + 8'(s)) >= {3'h0, up[4:0]}, expSec(cfg, s), s};
			rdWait(ADDR_STATUS, v, 100);
			cmp({carrierSense, secondAmpGain, ampGain}, v);
		end
		$display("test second amp and averaging done");
		// closed loop: strong signal drives gain to 0, weak one back to the ceiling
		for (int h = 0; h < 2; h++) begin
			wr(ADDR_GAIN_CFG, 8'h71 | 8'(h << 2));
			wr(ADDR_DOWN_START, 8'h38);
			wr(ADDR_UP_REF, 8'h38);
			sigLevel <= 8'hc8;
			slow <= h[0];
			pulse(1'b1);
			rdWait(ADDR_STATUS, 8'h80, 600);
			sigLevel <= 8'h00;
			pulse(1'b0);
			rdWait(ADDR_STATUS, 8'h98, 600);
		end
		$display("test gain loop done");
		complete_run();
	end
endmodule : rxagc_top_tb
